//--- pkg/txrx_defines.svh
`ifndef TXRX_DEFINES_SVH
`define TXRX_DEFINES_SVH
// register byte offsets
`define TXRX_OFS_CTRL   4'h0
`define TXRX_OFS_TXCMD  4'h4
`define TXRX_OFS_STAT   4'h8
`define TXRX_OFS_FIFO   4'hc
// control fields
`define TXRX_C_BUF      0
`define TXRX_C_ON       1
`define TXRX_C_LVL_LO   2
`define TXRX_C_LVL_HI   6
`define TXRX_C_DIV_LO   16
`define TXRX_C_DIV_HI   31
// status fields
`define TXRX_S_RDY      0
`define TXRX_S_LVL      1
`define TXRX_S_UR       2
`define TXRX_S_OV       3
`define TXRX_S_EMP      4
`define TXRX_S_CNT_LO   8
`define TXRX_S_CNT_HI   12
// fifo read fields
`define TXRX_F_BIT      0
`define TXRX_F_VLD      1
// values
`define TXRX_TX_INIT    8'haa
`define TXRX_TX_CMD_HI  8'hb8
`define TXRX_TXCMD_POR  16'hb8aa
`define TXRX_LVL_POR    5'h01
`define TXRX_DIV_POR    16'h01f3
`define TXRX_BYTE_LAST  3'h7
`endif

//--- pkg/txrx_pkg.sv
`default_nettype none
package txrx_pkg;
    typedef logic [31:0] txrx_word_t;                  // bus data word
    typedef enum logic {RX_HUNT = 1'b0, RX_FILL = 1'b1} txrx_rx_e; // receive gate
endpackage
`default_nettype wire

//--- hw/txrx_buf.sv
// Functional notes
// - buffered mode takes data from two registers
// - transmitter on sends first, then second register
// - both registers start at AAh preamble
// - sdo high while a register is free
// - transmitter off reloads both registers
// - received bits enter a 16-bit fifo
// - fill only after valid data and sync
// - fifo select shifts fifo bits per sck
// - fifo also readable by bus read
// - active-low irq when bit count reaches level
// - ready flag set free, cleared by write
// - level flag clears once a fifo read takes the count below level
// - write command upper byte B8h selects data
// - underrun and overflow clear on status read
//
// The implementer's own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "txrx_defines.svh"

////////////////////////////////////////////////////////////////////////
// bit fifo with count
module txrx_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 16,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic             clock_i,
    input  wire logic             rst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o,
    output logic [AW:0]           count_o
);
    logic [WIDTH-1:0] mem_reg [DEPTH];   // storage
    logic [AW-1:0]    wr_reg;            // write pointer
    logic [AW-1:0]    rd_reg;            // read pointer
    logic [AW:0]      cnt_reg;           // fill level
    logic             push;              // accepted write
    logic             pop;               // accepted read

    assign in_ready_o  = (cnt_reg != DEPTH[AW:0]);
    assign out_valid_o = (cnt_reg != '0);
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_ready_i & out_valid_o; // empty read ignored
    assign out_data_o  = mem_reg[rd_reg];           // oldest bit first
    assign count_o     = cnt_reg;

    // storage write, no reset needed on data
    always_ff @(posedge clock_i) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data_i;
        end
    end

    // pointers and level
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end

    a_empty_hold: assert property (@(posedge clock_i) disable iff (rst_i)
        !out_valid_o && out_ready_i && !in_valid_i |=> cnt_reg == '0 && $stable(rd_reg))
        else $error("empty read moved fifo");
endmodule // txrx_fifo

////////////////////////////////////////////////////////////////////////
// transmit registers and receive fifo
module txrx_buf #(
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic                clock_i,
    input  wire logic                rst_i,
    input  wire logic [3:0]          avs_address_i,
    input  wire logic                avs_read_i,
    input  wire logic                avs_write_i,
    input  wire txrx_pkg::txrx_word_t avs_writedata_i,
    output var  txrx_pkg::txrx_word_t avs_readdata_o,
    output logic                     avs_waitrequest_o,
    input  wire logic                sck_i,
    input  wire logic                fifo_select_n_i,
    output logic                     sdo_o,
    output logic                     fifo_level_irq_n_o,
    input  wire logic                tx_direct_i,
    output logic                     tx_data_o,
    input  wire logic                rx_bit_i,
    input  wire logic                rx_bit_stb_i,
    input  wire logic                valid_data_indicator_i,
    input  wire logic                sync_detect_i,
    output logic                     rx_ready_o
);
    import txrx_pkg::*;
    localparam int AW = $clog2(FIFO_DEPTH);

    ////////////////////////////////////////////////////////////////////
    // declarations
    logic        ack_reg;             // one wait state toggle
    logic        acc;                 // request accepted this edge
    txrx_word_t  rdata_reg;           // read data
    logic        buffered_tx_select;  // buffered transmit mode
    logic        transmitter_on;      // transmitter enable
    logic [4:0]  lvl_reg;             // fifo level threshold
    logic [15:0] div_reg;             // bit period in clocks minus one
    logic [15:0] cmd_reg;             // last accepted B8h data command
    logic [15:0] bcnt_reg;            // bit rate divider
    logic        tick;                // one-cycle bit enable
    logic [7:0]  tx_buf_reg [2];      // two transmit registers
    logic [1:0]  full_reg;            // register holds a byte
    logic        cur_reg;             // register being shifted
    logic [2:0]  bit_reg;             // bit index in byte
    logic        tx_reg_ready_flag;
    logic        tx_reg_underrun_flag;
    logic        rx_fifo_overflow_flag;
    logic        fifo_level_flag;
    logic        wr_fire;             // accepted transmit write
    logic        off_fire;            // transmitter switched off
    logic        byte_end;            // last bit of a byte shifted
    logic        tgt;                 // register taking the write
    logic        stat_rd;             // status read accepted
    logic        fifo_rd;             // fifo bus read accepted
    logic        sck_s1, sck_s2, sck_s3; // sck synchroniser and edge
    logic        ffs_s1, ffs_s2;      // select synchroniser
    logic        sck_pop;             // pin-side fifo pop
    txrx_rx_e    rx_state;            // receive gate
    logic        push;                // bit offered to fifo
    logic        f_ready, f_valid, f_data;
    logic [AW:0] f_count;

    ////////////////////////////////////////////////////////////////////
    // avalon slave: one wait state on every access
    assign acc               = (avs_read_i | avs_write_i) & ack_reg;
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_reg;
    assign avs_readdata_o    = rdata_reg;
    assign stat_rd  = acc & avs_read_i & (avs_address_i == `TXRX_OFS_STAT);
    assign fifo_rd  = acc & avs_read_i & (avs_address_i == `TXRX_OFS_FIFO);
    assign wr_fire  = acc & avs_write_i & (avs_address_i == `TXRX_OFS_TXCMD)
                    & (avs_writedata_i[15:8] == `TXRX_TX_CMD_HI) & buffered_tx_select;
    assign off_fire = acc & avs_write_i & (avs_address_i == `TXRX_OFS_CTRL)
                    & transmitter_on & ~avs_writedata_i[`TXRX_C_ON];

    // wait-state toggle; drops with the request
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (avs_read_i | avs_write_i) & ~ack_reg;
        end
    end

    // read data captured in the wait cycle, stands at the accept edge
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_reg <= '0;
        end else if (avs_read_i & ~ack_reg) begin
            rdata_reg <= '0;  // unmapped reads as zero
            unique case (avs_address_i)
                `TXRX_OFS_CTRL: begin
                    rdata_reg[`TXRX_C_BUF] <= buffered_tx_select;
                    rdata_reg[`TXRX_C_ON]  <= transmitter_on;
                    rdata_reg[`TXRX_C_LVL_HI:`TXRX_C_LVL_LO] <= lvl_reg;
                    rdata_reg[`TXRX_C_DIV_HI:`TXRX_C_DIV_LO] <= div_reg;
                end
                `TXRX_OFS_TXCMD: rdata_reg[15:0] <= cmd_reg;
                `TXRX_OFS_STAT: begin
                    rdata_reg[`TXRX_S_RDY] <= tx_reg_ready_flag;
                    rdata_reg[`TXRX_S_LVL] <= fifo_level_flag;
                    rdata_reg[`TXRX_S_UR]  <= tx_reg_underrun_flag;
                    rdata_reg[`TXRX_S_OV]  <= rx_fifo_overflow_flag;
                    rdata_reg[`TXRX_S_EMP] <= ~f_valid;
                    rdata_reg[`TXRX_S_CNT_HI:`TXRX_S_CNT_LO] <= 5'(f_count);
                end
                `TXRX_OFS_FIFO: begin
                    rdata_reg[`TXRX_F_BIT] <= f_data & f_valid; // empty reads zero, no stale bit
                    rdata_reg[`TXRX_F_VLD] <= f_valid;
                end
                default: rdata_reg <= '0;
            endcase
        end
    end

    // control and command registers
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            buffered_tx_select <= 1'b0;
            transmitter_on     <= 1'b0;
            lvl_reg            <= `TXRX_LVL_POR;
            div_reg            <= `TXRX_DIV_POR;
            cmd_reg            <= `TXRX_TXCMD_POR;
        end else if (acc & avs_write_i) begin
            if (avs_address_i == `TXRX_OFS_CTRL) begin
                buffered_tx_select <= avs_writedata_i[`TXRX_C_BUF];
                transmitter_on     <= avs_writedata_i[`TXRX_C_ON];
                lvl_reg <= avs_writedata_i[`TXRX_C_LVL_HI:`TXRX_C_LVL_LO];
                div_reg <= avs_writedata_i[`TXRX_C_DIV_HI:`TXRX_C_DIV_LO];
            end
            if (wr_fire) begin
                cmd_reg <= avs_writedata_i[15:0];
            end
        end
    end

    a_bus_wait: assert property (@(posedge clock_i) disable iff (rst_i)
        (avs_read_i | avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("bus answer late");

    ////////////////////////////////////////////////////////////////////
    // bit rate enable
    assign tick = (bcnt_reg == div_reg);
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            bcnt_reg <= '0;
        end else begin
            bcnt_reg <= (tick | ~transmitter_on) ? '0 : bcnt_reg + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // transmit registers: free one first, else overwrite the idle one
    assign byte_end = tick & transmitter_on & buffered_tx_select & (bit_reg == `TXRX_BYTE_LAST);
    assign tgt      = (~full_reg[~cur_reg] | full_reg[cur_reg]) ? ~cur_reg : cur_reg;

    // register contents, fill state and shift position
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            tx_buf_reg[0] <= `TXRX_TX_INIT;
            tx_buf_reg[1] <= `TXRX_TX_INIT;
            full_reg      <= 2'h3;
            cur_reg       <= 1'b0;
            bit_reg       <= '0;
        end else if (off_fire) begin
            tx_buf_reg[0] <= `TXRX_TX_INIT;
            tx_buf_reg[1] <= `TXRX_TX_INIT;
            full_reg      <= 2'h3;
            cur_reg       <= 1'b0;          // restart at first register
            bit_reg       <= '0;
        end else begin
            if (tick & transmitter_on & buffered_tx_select) begin
                bit_reg <= bit_reg + 1'b1;
            end
            if (byte_end) begin
                full_reg[cur_reg] <= 1'b0;
                cur_reg           <= ~cur_reg;  // next register, no gap
            end
            if (wr_fire) begin
                tx_buf_reg[tgt] <= avs_writedata_i[7:0];
                full_reg[tgt]   <= 1'b1;
            end
        end
    end

    // serial transmit bit: low while off, msb first in buffered mode, else direct input
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            tx_data_o <= 1'b0;
        end else if (~transmitter_on) begin
            tx_data_o <= 1'b0;
        end else if (~buffered_tx_select) begin
            tx_data_o <= tx_direct_i;
        end else if (tick) begin
            tx_data_o <= tx_buf_reg[cur_reg][~bit_reg];
        end
    end

    // flags: hardware set beats software clear
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            tx_reg_ready_flag    <= 1'b0;
            tx_reg_underrun_flag <= 1'b0;
        end else begin
            if (byte_end) begin
                tx_reg_ready_flag <= 1'b1;
            end else if (wr_fire | off_fire) begin
                tx_reg_ready_flag <= 1'b0;
            end
            if ((byte_end & ~full_reg[~cur_reg]) | (wr_fire & full_reg[tgt])) begin
                tx_reg_underrun_flag <= 1'b1;
            end else if (stat_rd) begin
                tx_reg_underrun_flag <= 1'b0;
            end
        end
    end

    sequence s_byte_end;
        byte_end && !off_fire;
    endsequence

    a_tx_next_reg: assert property (@(posedge clock_i) disable iff (rst_i)
        s_byte_end |=> cur_reg != $past(cur_reg) && tx_reg_ready_flag)
        else $error("tx did not move to other register");
    a_tx_msb_first: assert property (@(posedge clock_i) disable iff (rst_i)
        tick && transmitter_on && buffered_tx_select && !off_fire
        |=> tx_data_o == $past(tx_buf_reg[cur_reg][~bit_reg]))
        else $error("tx bit order wrong");
    a_tx_reload: assert property (@(posedge clock_i) disable iff (rst_i)
        off_fire |=> full_reg == 2'h3 && tx_buf_reg[0] == `TXRX_TX_INIT
                     && tx_buf_reg[1] == `TXRX_TX_INIT && cur_reg == 1'b0)
        else $error("tx registers not reloaded");
    a_ready_clear: assert property (@(posedge clock_i) disable iff (rst_i)
        wr_fire && !byte_end |=> !tx_reg_ready_flag)
        else $error("ready flag not cleared by write");
    a_cmd_filter: assert property (@(posedge clock_i) disable iff (rst_i)
        acc && avs_write_i && avs_address_i == `TXRX_OFS_TXCMD
        && avs_writedata_i[15:8] != `TXRX_TX_CMD_HI |=> $stable(full_reg) || $past(byte_end))
        else $error("foreign command loaded tx register");

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers and sck edge
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sck_s1 <= 1'b0;
            sck_s2 <= 1'b0;
            sck_s3 <= 1'b0;
            ffs_s1 <= 1'b1;
            ffs_s2 <= 1'b1;
        end else begin
            sck_s1 <= sck_i;
            sck_s2 <= sck_s1;
            sck_s3 <= sck_s2;
            ffs_s1 <= fifo_select_n_i;
            ffs_s2 <= ffs_s1;
        end
    end
    assign sck_pop = sck_s2 & ~sck_s3 & ~ffs_s2;

    ////////////////////////////////////////////////////////////////////
    // receive gate: open on valid data plus sync, close when valid drops
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rx_state <= RX_HUNT;
        end else begin
            unique case (rx_state)
                RX_HUNT: rx_state <= (valid_data_indicator_i & sync_detect_i) ? RX_FILL : RX_HUNT;
                RX_FILL: rx_state <= valid_data_indicator_i ? RX_FILL : RX_HUNT;
            endcase
        end
    end
    assign push = rx_bit_stb_i & valid_data_indicator_i
                & ((rx_state == RX_FILL) | sync_detect_i);
    assign rx_ready_o = f_ready;

    txrx_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clock_i     (clock_i),
        .rst_i       (rst_i),
        .in_valid_i  (push),
        .in_ready_o  (f_ready),
        .in_data_i   (rx_bit_i),
        .out_valid_o (f_valid),
        .out_ready_i (sck_pop | fifo_rd),
        .out_data_o  (f_data),
        .count_o     (f_count)
    );

    // level flag follows the count, so any read can clear it
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            fifo_level_flag       <= 1'b0;
            fifo_level_irq_n_o    <= 1'b1;
            rx_fifo_overflow_flag <= 1'b0;
        end else begin
            fifo_level_flag    <= (f_count >= lvl_reg);
            fifo_level_irq_n_o <= ~(f_count >= lvl_reg);
            if (push & ~f_ready) begin
                rx_fifo_overflow_flag <= 1'b1;
            end else if (stat_rd) begin
                rx_fifo_overflow_flag <= 1'b0;
            end
        end
    end

    // sdo: fifo head under select, else transmit ready in buffered mode
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sdo_o <= 1'b0;
        end else if (~ffs_s2) begin
            sdo_o <= f_data;
        end else begin
            sdo_o <= buffered_tx_select & tx_reg_ready_flag;
        end
    end

    a_rx_noise: assert property (@(posedge clock_i) disable iff (rst_i)
        rx_state == RX_HUNT && !sync_detect_i && !$past(push) |=> $stable(f_count) || $past(sck_pop | fifo_rd))
        else $error("noise entered fifo");
    a_sck_pop: assert property (@(posedge clock_i) disable iff (rst_i)
        sck_pop && f_valid && !push |=> f_count == $past(f_count) - 1'b1)
        else $error("sck edge did not pop fifo");
    a_bus_pop: assert property (@(posedge clock_i) disable iff (rst_i)
        fifo_rd && f_valid && !push |=> f_count == $past(f_count) - 1'b1)
        else $error("bus read did not pop fifo");
    a_irq_level: assert property (@(posedge clock_i) disable iff (rst_i)
        f_count >= lvl_reg |=> !fifo_level_irq_n_o && fifo_level_flag)
        else $error("level irq missing");
    a_ovf_flag: assert property (@(posedge clock_i) disable iff (rst_i)
        push && !f_ready |=> rx_fifo_overflow_flag [*1] ##1 1'b1)
        else $error("overflow not flagged");
    a_sdo_ready: assert property (@(posedge clock_i) disable iff (rst_i)
        ffs_s2 |=> sdo_o == $past(buffered_tx_select & tx_reg_ready_flag))
        else $error("sdo ready wrong");
endmodule // txrx_buf
`default_nettype wire

//--- bench/txrx_host_model.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////
// host side of the fifo pins; sck stands low outside frames
module txrx_host_model (
    input  wire logic sdo_i,
    output logic      sck_o,
    output logic      sel_n_o
);
    initial begin
        sck_o   = 1'b0;
        sel_n_o = 1'b1;
    end
    // clock n bits out; the first bit ends up at bit n-1 of v
    task automatic read_bits(input int n, output logic [15:0] v);
        v = 16'h0;
        sel_n_o = 1'b0;
        #1003;
        repeat (n) begin
            v = {v[14:0], sdo_i}; // sampled before the rising edge
            sck_o = 1'b1;
            #80; // 160 ns period, slower than a quarter of the reference
            sck_o = 1'b0;
            #80;
        end
        sel_n_o = 1'b1;
    endtask
endmodule // txrx_host_model
`default_nettype wire

//--- bench/txrx_buf_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////
// bench: bus reads are noted in a queue and checked by a monitor
module txrx_buf_tb_top;
    import txrx_pkg::*;
    logic        clk;
    logic        rst;
    logic [3:0]  adr;
    logic        rd, wr, wreq, sdo, irqn, txd, rxr;
    logic        sck, seln, txdir, rxb, stb, valid_data_indicator, syn;
    txrx_word_t  wd, rdd;
    txrx_word_t  eq[$], mq[$];   // expected read data and compare mask
    logic        txq[$];         // tx line, one sample per clock
    logic        cap;
    logic [15:0] rv, v;
    logic [23:0] xs;
    int          fails = 0, num_checks = 0, seed = 24715, i, k;

    always #10 clk = ~clk;

    txrx_buf uut (.clock_i(clk), .rst_i(rst), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdd), .avs_waitrequest_o(wreq),
        .sck_i(sck), .fifo_select_n_i(seln), .sdo_o(sdo), .fifo_level_irq_n_o(irqn),
        .tx_direct_i(txdir), .tx_data_o(txd), .rx_bit_i(rxb), .rx_bit_stb_i(stb),
        .valid_data_indicator_i(valid_data_indicator), .sync_detect_i(syn), .rx_ready_o(rxr));
    txrx_host_model host (.sdo_i(sdo), .sck_o(sck), .sel_n_o(seln));

    ////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // plain value compare
    task automatic chk(input logic ok);
        num_checks++;
        if (ok !== 1'b1) begin
            fails++;
            $display("BAD %0t value mismatch", $time);
        end
    endtask
    // bus read data compare, oldest note first
    task automatic chk_rd();
        txrx_word_t e, m;
        num_checks++;
        if (eq.size() == 0) begin
            fails++;
            $display("BAD %0t unexpected read", $time);
        end else begin
            e = eq.pop_front();
            m = mq.pop_front();
            if ((rdd & m) !== (e & m)) begin
                fails++;
                $display("BAD %0t read %h want %h", $time, rdd, e);
            end
        end
    endtask
    // one avalon cycle; held until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [3:0] a, input txrx_word_t d, input txrx_word_t m);
        int n;
        if (!w) begin
            eq.push_back(d);
            mq.push_back(m);
        end
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= w ? d : 32'h0;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (wreq === 1'b0) break;
        end
        rd <= 1'b0;
        wr <= 1'b0;
        if (n == 20) begin
            fails++;
            give_verdict();
        end
    endtask
    // one received bit with its gate qualifiers
    task automatic push(input logic b, input logic va, input logic sy);
        @(posedge clk);
        rxb <= b;
        stb <= 1'b1;
        valid_data_indicator <= va;
        syn <= sy;
        @(posedge clk);
        stb <= 1'b0;
    endtask

    ////////////////////////////////////////
    // monitor: a read result appears at the edge that accepts it
    always @(posedge clk) begin
        if (rd === 1'b1 && wreq === 1'b0) chk_rd();
        if (cap) txq.push_back(txd);
    end
    // hang guard
    initial begin
        #400000;
        fails++;
        give_verdict();
    end

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        {rd, wr, adr, wd, txdir, rxb, stb, valid_data_indicator, syn, cap} = '0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        // reset contents and an unmapped hole
        bus(0, 4'h0, 32'h01f3_0004, '1);
        bus(0, 4'h4, 32'hb8aa, 32'hffff);
        bus(0, 4'h8, 32'h10, 32'h1f1f);
        bus(1, 4'h2, '1, 0);
        bus(0, 4'h2, 0, '1);
        // preamble, then a loaded byte; divider 3 gives 4 clocks a bit
        cap <= 1'b1;
        bus(1, 4'h0, 32'h0003_0007, 0);
        for (i = 0; i < 200 && sdo !== 1'b1; i++) @(posedge clk);
        chk(sdo === 1'b1);
        bus(1, 4'h4, 32'hb83c, 0);
        bus(0, 4'h8, 0, 1);
        chk(sdo === 1'b0);
        bus(1, 4'h4, 32'h9955, 0);
        bus(0, 4'h4, 32'hb83c, 32'hffff);
        repeat (120) @(posedge clk);
        cap <= 1'b0;
        xs = 24'haaaa3c;
        for (i = 0; i < 40 && txq[i] !== 1'b1; i++);
        for (k = 0; k < 24; k++) chk(txq[i+2+4*k] === xs[23-k]);
        // off reloads both registers; underrun seen once
        bus(1, 4'h0, 32'h0003_0005, 0);
        bus(0, 4'h8, 32'h4, 32'h5);
        bus(0, 4'h8, 0, 32'h5);
        // direct mode copies the input bit one clock later
        bus(1, 4'h0, 32'h0003_0006, 0);
        for (k = 0; k < 4; k++) begin
            txdir <= 1'($random(seed));
            repeat (2) @(posedge clk);
            chk(txd === txdir);
        end
        // noise never fills the fifo
        push(1'b1, 1'b1, 1'b0);
        push(1'b1, 1'b0, 1'b1);
        bus(0, 4'h8, 32'h10, 32'h1f10);
        rv = 16'($random(seed));
        for (k = 15; k >= 0; k--) push(rv[k], 1'b1, k == 15);
        push(1'b0, 1'b1, 1'b0);
        repeat (2) @(posedge clk);
        chk(irqn === 1'b0);
        chk(rxr === 1'b0);
        bus(0, 4'h8, 32'h100a, 32'h1f1e);
        bus(0, 4'h8, 32'h1002, 32'h1f1e);
        host.read_bits(8, v);
        chk(v[7:0] === rv[15:8]);
        // poll the level output, draining over the bus
        k = 0;
        for (i = 0; i < 16; i++) begin
            repeat (2) @(posedge clk);
            if (irqn !== 1'b0) break;
            bus(0, 4'hc, {30'h0, 1'b1, rv[7-k]}, 32'h3);
            k++;
        end
        chk(k == 8);
        bus(0, 4'hc, 0, 32'h3);
        bus(0, 4'h8, 32'h10, 32'h1f12);
        give_verdict();
    end
endmodule // txrx_buf_tb_top
`default_nettype wire
